// [src/mbr_slave.sv]
// Receive FIFO and the slave end of the register link
// What this block does
// - Reply opens with configured station number
// - Read holding: fields, counted high-low words
// - Read input: same layout as holding read
// - Single write: echo address and data
// - Multiple write: echo address and count
// - Exception codes 01, 02, 03, 06
// - Exception: station, function|80, code, check
// - Master sends address minus one
`timescale 1ns/1ns
module mbr_fifo
	import mbr_pkg::*;
#(
	parameter int W = 9,
	parameter int D = FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Fill side
	input wire logic IN_VALID,
	input wire logic [W-1:0] IN_DATA,
	output logic IN_READY,
	// Drain side
	output logic OUT_VALID,
	output logic [W-1:0] OUT_DATA,
	input wire logic OUT_READY
);
	localparam int AW = $clog2(D);
	// Storage and pointers with a wrap bit
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} mbr_fifo_state_t;
	mbr_fifo_state_t s;
	mbr_fifo_state_t n;
	logic full;
	logic empty;
	// Full when pointers differ only in the wrap bit
	assign full = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
	assign empty = (s.wp == s.rp);
	assign IN_READY = !full;
	assign OUT_VALID = !empty;
	assign OUT_DATA = s.mem[s.rp[AW-1:0]];
	// Next pointers and write
	always_comb
	begin
		n = s;
		if (IN_VALID && !full)
		begin
			n.mem[s.wp[AW-1:0]] = IN_DATA;
			n.wp = s.wp + 1'b1;
		end
		if (OUT_READY && !empty)
		begin
			n.rp = s.rp + 1'b1;
		end
	end
	// State register
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			s <= '0;
		else
			s <= n;
	end
endmodule

module mbr_slave
	import mbr_pkg::*;
#(
	parameter int N_REGS = NUM_REGS,
	parameter int MAX_PTS = MAX_POINTS
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Link to the master
	mbr_link_if.dev LINK,
	// Configuration
	input wire logic [7:0] SERIAL_STATION_NUMBER,
	input wire logic BUSY,
	// Register contents
	input wire logic [N_REGS-1:0][15:0] INPUT_REGS,
	output logic [N_REGS-1:0][15:0] HOLDING_REGS,
	output logic WRITE_STROBE
);
	// Longest request held
	localparam int RQ = 9 + 2 * MAX_PTS;
	typedef enum logic [1:0] {S_RX, S_EXEC, S_TX} mbr_slv_st_t;
	// Whole slave state
	typedef struct packed {
		mbr_slv_st_t st;
		logic [4:0] rx_cnt;
		logic rx_ovf;
		logic [15:0] crc;
		logic [RQ-1:0][7:0] rbuf;
		logic [7:0] exc;
		logic [5:0] tx_idx;
		logic [5:0] tx_len;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_last;
		logic [N_REGS-1:0][15:0] regs;
		logic wr_pulse;
	} mbr_slv_state_t;
	mbr_slv_state_t s;
	mbr_slv_state_t n;
	// FIFO drain side
	logic f_valid;
	logic [8:0] f_data;
	logic f_ready;
	// Decoded request fields
	logic [7:0] fn;
	logic [15:0] addr;
	logic [15:0] cnt;
	logic is_read;
	logic is_multi;
	logic [16:0] span;
	logic [15:0] exp_len;
	assign f_ready = (s.st == S_RX);
	// --------------------------------------------------------------
	// Receive buffer, stalls the link when full
	// --------------------------------------------------------------
	mbr_fifo #(.W(9), .D(FIFO_DEPTH)) u_rx_fifo (
		.MCLK(MCLK),
		.SYS_RST(SYS_RST),
		.IN_VALID(LINK.m2s_valid),
		.IN_DATA({LINK.m2s_last, LINK.m2s_data}),
		.IN_READY(LINK.m2s_ready),
		.OUT_VALID(f_valid),
		.OUT_DATA(f_data),
		.OUT_READY(f_ready)
	);
	// --------------------------------------------------------------
	// Request decode
	// --------------------------------------------------------------
	assign fn = s.rbuf[1];
	assign addr = {s.rbuf[2], s.rbuf[3]};
	assign cnt = {s.rbuf[4], s.rbuf[5]};
	assign is_read = (fn == FN_RD_HOLD) || (fn == FN_RD_INPUT);
	assign is_multi = (fn == FN_WR_MULTI);
	// Last register touched plus one
	assign span = {1'b0, addr} + ((fn == FN_WR_SINGLE) ? 17'h0_0001 : {1'b0, cnt});
	// Expected request length in bytes
	assign exp_len = is_multi ? (16'h0009 + {cnt[14:0], 1'b0}) : 16'h0008;
	// Outputs
	assign LINK.s2m_valid = s.tx_valid;
	assign LINK.s2m_data = s.tx_data;
	assign LINK.s2m_last = s.tx_last;
	assign HOLDING_REGS = s.regs;
	assign WRITE_STROBE = s.wr_pulse;
	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		logic [7:0] rb;
		int ri;
		logic [15:0] word;
		logic [5:0] off;
		rb = 8'h00;
		ri = 0;
		word = 16'h0000;
		off = 6'd0;
		n = s;
		n.wr_pulse = 1'b0;
		unique case (s.st)
			S_RX:
			begin
				// Collect bytes and run the check
				if (f_valid)
				begin
					if (s.rx_cnt < 5'(RQ))
					begin
						n.rbuf[s.rx_cnt] = f_data[7:0];
						n.rx_cnt = s.rx_cnt + 5'd1;
					end
					else
						n.rx_ovf = 1'b1;
					n.crc = mbr_crc_step(s.crc, f_data[7:0]);
					if (f_data[8])
					begin
						if (!n.rx_ovf && n.rx_cnt >= 5'd4 && n.crc == 16'h0000
							&& n.rbuf[0] == SERIAL_STATION_NUMBER)
							n.st = S_EXEC;
						else
						begin
							n.rx_cnt = 5'd0;
							n.rx_ovf = 1'b0;
						end
						n.crc = CRC_INIT;
					end
				end
			end
			S_EXEC:
			begin
				if (!is_read && !is_multi && fn != FN_WR_SINGLE)
					n.exc = EXC_FUNC;
				else if (BUSY)
					n.exc = EXC_BUSY;
				else if ((is_read || is_multi) && (cnt == 16'h0000 || cnt > 16'(MAX_PTS)))
					n.exc = EXC_VALUE;
				else if ({11'h000, s.rx_cnt} != exp_len || (is_multi && s.rbuf[6] != {cnt[6:0], 1'b0}))
					n.exc = EXC_VALUE;
				else if (span > 17'(N_REGS))
					n.exc = EXC_ADDR;
				else
					n.exc = EXC_NONE;
				if (n.exc == EXC_NONE && fn == FN_WR_SINGLE)
				begin
					n.regs[addr[7:0]] = cnt;
					n.wr_pulse = 1'b1;
				end
				if (n.exc == EXC_NONE && is_multi)
				begin
					for (int i = 0; i < MAX_PTS; i++)
					begin
						if (i < int'(cnt))
							n.regs[int'(addr) + i] = {s.rbuf[7 + 2 * i], s.rbuf[8 + 2 * i]};
					end
					n.wr_pulse = 1'b1;
				end
				// Reply body length without the check
				if (n.exc != EXC_NONE)
					n.tx_len = 6'd3;
				else if (is_read)
					n.tx_len = 6'd3 + {cnt[4:0], 1'b0};
				else
					n.tx_len = 6'd6;
				n.tx_idx = 6'd0;
				n.crc = CRC_INIT;
				n.st = S_TX;
			end
			S_TX:
			begin
				// Reply byte for this position, echo by default
				if (s.tx_idx < 6'(RQ))
					rb = s.rbuf[s.tx_idx];
				off = s.tx_idx - 6'd3;
				ri = int'(addr) + int'(off[5:1]);
				if (ri < N_REGS)
					word = (fn == FN_RD_INPUT) ? INPUT_REGS[ri] : s.regs[ri];
				if (s.tx_idx == 6'd0)
					rb = SERIAL_STATION_NUMBER;
				else if (s.exc != EXC_NONE)
					rb = (s.tx_idx == 6'd1) ? (fn | EXC_FLAG) : s.exc;
				else if (is_read && s.tx_idx == 6'd2)
					rb = {cnt[6:0], 1'b0};
				else if (is_read && s.tx_idx >= 6'd3)
					rb = off[0] ? word[7:0] : word[15:8];
				// Send when the slot is free
				if (!s.tx_valid || LINK.s2m_ready)
				begin
					if (s.tx_idx < s.tx_len + 6'd2)
					begin
						n.tx_valid = 1'b1;
						n.tx_last = (s.tx_idx == s.tx_len + 6'd1);
						n.tx_idx = s.tx_idx + 6'd1;
						if (s.tx_idx < s.tx_len)
						begin
							n.tx_data = rb;
							n.crc = mbr_crc_step(s.crc, rb);
						end
						else
							n.tx_data = (s.tx_idx == s.tx_len) ? s.crc[7:0] : s.crc[15:8];
					end
					else
					begin
						n.tx_valid = 1'b0;
						n.tx_last = 1'b0;
						n.rx_cnt = 5'd0;
						n.crc = CRC_INIT;
						n.st = S_RX;
					end
				end
			end
		endcase
	end
	// State register
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s <= '0;
			s.crc <= CRC_INIT;
		end
		else
			s <= n;
	end
endmodule

// [src/mbr_pkg.sv]
// Shared constants, codes and the frame check step for the register link
package mbr_pkg;
	// --------------------------------------------------------------
	// Function and exception codes
	// --------------------------------------------------------------
	localparam logic [7:0] FN_RD_HOLD = 8'h03;
	localparam logic [7:0] FN_RD_INPUT = 8'h04;
	localparam logic [7:0] FN_WR_SINGLE = 8'h06;
	localparam logic [7:0] FN_WR_MULTI = 8'h10;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;
	localparam logic [7:0] EXC_BUSY = 8'h06;
	// Top bit marking an exception reply
	localparam logic [7:0] EXC_FLAG = 8'h80;
	// --------------------------------------------------------------
	// Sizes and timing
	// --------------------------------------------------------------
	// Most registers in one read or multiple write
	localparam int MAX_POINTS = 8;
	// Registers held by the slave
	localparam int NUM_REGS = 16;
	// Receive FIFO depth, a power of two
	localparam int FIFO_DEPTH = 8;
	// Master wait for a reply, in clock cycles
	localparam int RSP_TIMEOUT_CYC = 100000;
	// --------------------------------------------------------------
	// Frame check
	// --------------------------------------------------------------
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	// One byte through the reflected frame check
	function automatic logic [15:0] mbr_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// [src/mbr_link_if.sv]
// Byte stream link between the bus master and the register slave
`timescale 1ns/1ns
interface mbr_link_if;
	// Master to slave bytes
	logic m2s_valid;
	logic [7:0] m2s_data;
	logic m2s_last;
	logic m2s_ready;
	// Slave to master bytes
	logic s2m_valid;
	logic [7:0] s2m_data;
	logic s2m_last;
	logic s2m_ready;
	// Slave end
	modport dev(input m2s_valid, input m2s_data, input m2s_last, output m2s_ready,
		output s2m_valid, output s2m_data, output s2m_last, input s2m_ready);
	// Master end
	modport host(output m2s_valid, output m2s_data, output m2s_last, input m2s_ready,
		input s2m_valid, input s2m_data, input s2m_last, output s2m_ready);
endinterface

// [src/mbr_master.sv]
// Master end of the register link: builds requests, parses replies
`timescale 1ns/1ns
module mbr_master
	import mbr_pkg::*;
#(
	parameter int MAX_PTS = MAX_POINTS,
	parameter int TIMEOUT = RSP_TIMEOUT_CYC
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Link to the slave
	mbr_link_if.host LINK,
	// Command
	input wire logic CMD_VALID,
	output logic CMD_READY,
	input wire logic [7:0] CMD_STATION,
	input wire logic [7:0] CMD_FUNC,
	input wire logic [15:0] CMD_ADDR,
	input wire logic [15:0] CMD_COUNT,
	input wire logic [MAX_PTS-1:0][15:0] CMD_DATA,
	// Reply
	output logic RSP_VALID,
	output logic [7:0] RSP_FUNC,
	output logic [7:0] RSP_EXC,
	output logic RSP_CRC_ERR,
	output logic RSP_TIMEOUT,
	output logic [MAX_PTS-1:0][15:0] RSP_DATA
);
	// Longest reply held
	localparam int RB = 5 + 2 * MAX_PTS;
	typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} mbr_mst_st_t;
	// Whole master state
	typedef struct packed {
		mbr_mst_st_t st;
		logic [7:0] station;
		logic [7:0] func;
		logic [15:0] addr;
		logic [15:0] cnt;
		logic [MAX_PTS-1:0][15:0] data;
		logic [5:0] tx_idx;
		logic [5:0] tx_len;
		logic [15:0] crc;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_last;
		logic [RB-1:0][7:0] rbuf;
		logic [4:0] rx_cnt;
		logic [31:0] timer;
		logic rsp_valid;
		logic [7:0] rsp_func;
		logic [7:0] rsp_exc;
		logic rsp_crc_err;
		logic rsp_timeout;
		logic [MAX_PTS-1:0][15:0] rsp_data;
	} mbr_mst_state_t;
	mbr_mst_state_t s;
	mbr_mst_state_t n;
	// Outputs
	assign CMD_READY = (s.st == M_IDLE);
	assign LINK.m2s_valid = s.tx_valid;
	assign LINK.m2s_data = s.tx_data;
	assign LINK.m2s_last = s.tx_last;
	assign LINK.s2m_ready = 1'b1;
	assign RSP_VALID = s.rsp_valid;
	assign RSP_FUNC = s.rsp_func;
	assign RSP_EXC = s.rsp_exc;
	assign RSP_CRC_ERR = s.rsp_crc_err;
	assign RSP_TIMEOUT = s.rsp_timeout;
	assign RSP_DATA = s.rsp_data;
	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		logic [7:0] rb;
		logic [5:0] off;
		logic single;
		rb = 8'h00;
		off = s.tx_idx - 6'd7;
		single = (s.func == FN_WR_SINGLE);
		n = s;
		n.rsp_valid = 1'b0;
		unique case (s.st)
			M_IDLE:
			begin
				// Take a command
				if (CMD_VALID)
				begin
					n.station = CMD_STATION;
					n.func = CMD_FUNC;
					// Address field is address minus one
					n.addr = CMD_ADDR - 16'h0001;
					n.cnt = (CMD_COUNT > 16'(MAX_PTS)) ? 16'(MAX_PTS) : CMD_COUNT;
					n.data = CMD_DATA;
					n.tx_len = (CMD_FUNC == FN_WR_MULTI) ? (6'd7 + {n.cnt[4:0], 1'b0}) : 6'd6;
					n.tx_idx = 6'd0;
					n.crc = CRC_INIT;
					n.st = M_SEND;
				end
			end
			M_SEND:
			begin
				unique case (s.tx_idx)
					6'd0: rb = s.station;
					6'd1: rb = s.func;
					6'd2: rb = s.addr[15:8];
					6'd3: rb = s.addr[7:0];
					6'd4: rb = single ? s.data[0][15:8] : s.cnt[15:8];
					6'd5: rb = single ? s.data[0][7:0] : s.cnt[7:0];
					6'd6: rb = {s.cnt[6:0], 1'b0};
					default:
					begin
						if (int'(off[5:1]) < MAX_PTS)
							rb = off[0] ? s.data[off[5:1]][7:0] : s.data[off[5:1]][15:8];
					end
				endcase
				// Send when the slot is free
				if (!s.tx_valid || LINK.m2s_ready)
				begin
					if (s.tx_idx < s.tx_len + 6'd2)
					begin
						n.tx_valid = 1'b1;
						n.tx_last = (s.tx_idx == s.tx_len + 6'd1);
						n.tx_idx = s.tx_idx + 6'd1;
						if (s.tx_idx < s.tx_len)
						begin
							n.tx_data = rb;
							n.crc = mbr_crc_step(s.crc, rb);
						end
						else
							n.tx_data = (s.tx_idx == s.tx_len) ? s.crc[7:0] : s.crc[15:8];
					end
					else
					begin
						n.tx_valid = 1'b0;
						n.tx_last = 1'b0;
						n.rx_cnt = 5'd0;
						n.crc = CRC_INIT;
						n.timer = 32'h0000_0000;
						n.st = M_WAIT;
					end
				end
			end
			M_WAIT:
			begin
				n.timer = s.timer + 32'h0000_0001;
				// Collect the reply
				if (LINK.s2m_valid)
				begin
					if (s.rx_cnt < 5'(RB))
					begin
						n.rbuf[s.rx_cnt] = LINK.s2m_data;
						n.rx_cnt = s.rx_cnt + 5'd1;
					end
					n.crc = mbr_crc_step(s.crc, LINK.s2m_data);
					if (LINK.s2m_last)
					begin
						n.rsp_valid = 1'b1;
						n.rsp_timeout = 1'b0;
						n.rsp_crc_err = (n.crc != 16'h0000);
						n.rsp_func = n.rbuf[1];
						n.rsp_exc = n.rbuf[1][7] ? n.rbuf[2] : EXC_NONE;
						for (int i = 0; i < MAX_PTS; i++)
						begin
							n.rsp_data[i] = {n.rbuf[3 + 2 * i], n.rbuf[4 + 2 * i]};
						end
						n.st = M_IDLE;
					end
				end
				// No reply in time
				else if (s.timer >= 32'(TIMEOUT - 1))
				begin
					n.rsp_valid = 1'b1;
					n.rsp_timeout = 1'b1;
					n.rsp_crc_err = 1'b0;
					n.st = M_IDLE;
				end
			end
			default: n.st = M_IDLE;
		endcase
	end
	// State register
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s <= '0;
			s.crc <= CRC_INIT;
		end
		else
			s <= n;
	end
endmodule

// [test/mbr_link_sva.sv]
// Checker for the byte link between the master and slave ends
`timescale 1ns/1ns
module mbr_link_sva
	import mbr_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Request stream
	input wire logic m2s_valid,
	input wire logic [7:0] m2s_data,
	input wire logic m2s_last,
	input wire logic m2s_ready,
	// Reply stream
	input wire logic s2m_valid,
	input wire logic [7:0] s2m_data,
	input wire logic s2m_last,
	input wire logic s2m_ready,
	// Station setting of the slave
	input wire logic [7:0] SERIAL_STATION_NUMBER
);
	// ----------------------------------------
	// Frame tracking
	// ----------------------------------------
	// Frame check, kept apart from the design's own
	function automatic logic [15:0] ck_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
		end
		return r;
	endfunction
	logic [4:0] rq_ff; // Request byte index
	logic [4:0] rp_ff; // Reply byte index
	logic [15:0] rqc_ff; // Request running check
	logic [15:0] rpc_ff; // Reply running check
	logic [7:0] rp1_ff; // Reply function byte
	logic [7:0] rp2_ff; // Reply third byte
	logic [7:0] rqb_ff [8]; // First request bytes
	wire rq_t = m2s_valid && m2s_ready;
	wire rp_t = s2m_valid && s2m_ready;
	wire [15:0] rqc_nx = ck_step(rqc_ff, m2s_data);
	wire [15:0] rpc_nx = ck_step(rpc_ff, s2m_data);
	// Whole request for this station with a good check
	wire rq_ok = rq_t && m2s_last && rqc_nx == 16'h0000 && rqb_ff[0] == SERIAL_STATION_NUMBER
		&& rq_ff >= 5'h03 && rq_ff <= 5'h18;
	// Index and check registers of both streams
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			rq_ff <= 5'h00;
			rp_ff <= 5'h00;
			rqc_ff <= 16'hFFFF;
			rpc_ff <= 16'hFFFF;
			rp1_ff <= 8'h00;
			rp2_ff <= 8'h00;
			for (int i = 0; i < 8; i++)
			begin
				rqb_ff[i] <= 8'h00;
			end
		end
		else
		begin
			// Request byte taken
			if (rq_t)
			begin
				rq_ff <= m2s_last ? 5'h00 : rq_ff + 5'h01;
				rqc_ff <= m2s_last ? 16'hFFFF : rqc_nx;
				if (rq_ff < 5'h08)
				begin
					rqb_ff[rq_ff[2:0]] <= m2s_data;
				end
			end
			// Reply byte taken
			if (rp_t)
			begin
				rp_ff <= s2m_last ? 5'h00 : rp_ff + 5'h01;
				rpc_ff <= s2m_last ? 16'hFFFF : rpc_nx;
				if (rp_ff == 5'h01)
				begin
					rp1_ff <= s2m_data;
				end
				if (rp_ff == 5'h02)
				begin
					rp2_ff <= s2m_data;
				end
			end
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	a_reply_station: assert property (rp_t && rp_ff == 5'h00 |-> s2m_data == SERIAL_STATION_NUMBER)
		else $error("reply does not open with the station");
	a_func_echo: assert property (rp_t && rp_ff == 5'h01 |-> (s2m_data & 8'h7F) == rqb_ff[1])
		else $error("reply function differs from request");
	a_exc_code: assert property (rp_t && rp_ff == 5'h02 && rp1_ff[7] |-> s2m_data inside {8'h01, 8'h02, 8'h03, 8'h06})
		else $error("exception code out of set");
	a_exc_length: assert property (rp_t && s2m_last && rp1_ff[7] |-> rp_ff == 5'h04)
		else $error("exception reply length wrong");
	a_read_count: assert property (rp_t && s2m_last && (rp1_ff == FN_RD_HOLD || rp1_ff == FN_RD_INPUT)
		|-> rp2_ff == {rqb_ff[5][6:0], 1'b0} && rp_ff == rp2_ff[4:0] + 5'h04)
		else $error("read reply count or length wrong");
	a_single_echo: assert property (rp_t && rp_ff >= 5'h02 && rp1_ff == FN_WR_SINGLE
		|-> s2m_data == rqb_ff[rp_ff[2:0]] && s2m_last == (rp_ff == 5'h07))
		else $error("single write reply is not an echo");
	a_multi_echo: assert property (rp_t && rp_ff >= 5'h02 && rp1_ff == FN_WR_MULTI
		|-> (rp_ff > 5'h05 || s2m_data == rqb_ff[rp_ff[2:0]]) && s2m_last == (rp_ff == 5'h07))
		else $error("multiple write reply wrong");
	a_reply_check: assert property (rp_t && s2m_last |-> rpc_nx == 16'h0000)
		else $error("reply frame check wrong");
	a_reply_prompt: assert property (rq_ok |-> ##[2:60] s2m_valid)
		else $error("no reply to a good request");
	a_foreign_silent: assert property (rq_t && m2s_last && rqb_ff[0] != SERIAL_STATION_NUMBER |=> !s2m_valid [*8])
		else $error("reply to another station");
endmodule

// [test/testbench.sv]
// Testbench joining master and slave ends, plus a raw link into a second slave
`timescale 1ns/1ns
module testbench;
	import mbr_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] station = 8'h11;
	logic busy = 1'b0;
	logic [15:0][15:0] in_regs;
	logic [15:0][15:0] hold_regs;
	logic wr_strobe;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	logic [7:0] cmd_st = 8'h00;
	logic [7:0] cmd_fn = 8'h00;
	logic [15:0] cmd_addr = 16'h0000;
	logic [15:0] cmd_cnt = 16'h0000;
	logic [7:0][15:0] cmd_data = '0;
	logic rsp_valid;
	logic [7:0] rsp_fn;
	logic [7:0] rsp_exc;
	logic rsp_to;
	logic rsp_crc;
	logic [7:0][15:0] rsp_data;
	int failures = 0;
	int checked = 0;
	int strobes = 0;
	mbr_link_if link();
	mbr_link_if link_b();
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	mbr_slave #(.N_REGS(16), .MAX_PTS(8)) u_mbr_slave (.MCLK(clk), .SYS_RST(rst), .LINK(link),
		.SERIAL_STATION_NUMBER(station), .BUSY(busy), .INPUT_REGS(in_regs), .HOLDING_REGS(hold_regs),
		.WRITE_STROBE(wr_strobe));
	mbr_slave u_mbr_slave_b (.MCLK(clk), .SYS_RST(rst), .LINK(link_b),
		.SERIAL_STATION_NUMBER(station), .BUSY(busy), .INPUT_REGS(in_regs), .HOLDING_REGS(), .WRITE_STROBE());
	mbr_master #(.MAX_PTS(8), .TIMEOUT(200)) u_mbr_master (.MCLK(clk), .SYS_RST(rst), .LINK(link),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_STATION(cmd_st), .CMD_FUNC(cmd_fn), .CMD_ADDR(cmd_addr),
		.CMD_COUNT(cmd_cnt), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_FUNC(rsp_fn), .RSP_EXC(rsp_exc),
		.RSP_CRC_ERR(rsp_crc), .RSP_TIMEOUT(rsp_to), .RSP_DATA(rsp_data));
	mbr_link_sva u_mbr_link_sva (.MCLK(clk), .SYS_RST(rst), .m2s_valid(link.m2s_valid), .m2s_data(link.m2s_data),
		.m2s_last(link.m2s_last), .m2s_ready(link.m2s_ready), .s2m_valid(link.s2m_valid), .s2m_data(link.s2m_data),
		.s2m_last(link.s2m_last), .s2m_ready(link.s2m_ready), .SERIAL_STATION_NUMBER(station));
	// Clock, 20 ns period
	always #10 clk = ~clk;
	// Count write pulses
	always @(posedge clk)
	begin
		if (wr_strobe === 1'b1)
			strobes++;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic logic [15:0] tb_crc(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		return c;
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One command to the master, then wait for its reply
	task automatic cmd(input logic [7:0] fn, input logic [15:0] addr, input logic [15:0] cnt, input logic [7:0] st);
		int n;
		cmd_st = st;
		cmd_fn = fn;
		cmd_addr = addr;
		cmd_cnt = cnt;
		cmd_valid = 1'b1;
		for (n = 0; cmd_ready !== 1'b1 && n < 50; n++)
			@(posedge clk) #1;
		@(posedge clk) #1;
		cmd_valid = 1'b0;
		for (n = 0; rsp_valid !== 1'b1 && n < 400; n++)
			@(posedge clk) #1;
		chk("reply pulse", 16'h0001, {15'h0000, rsp_valid});
		chk("reply check", 16'h0000, {15'h0000, rsp_crc});
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_writes();
		int s0;
		s0 = strobes;
		cmd_data[0] = 16'h1234;
		cmd(FN_WR_SINGLE, 16'h0003, 16'h0001, station);
		chk("single exc", 16'h0000, {8'h00, rsp_exc});
		chk("single reg", 16'h1234, hold_regs[2]);
		chk("single strobe", 16'h0001, 16'(strobes - s0));
		for (int i = 0; i < 8; i++)
			cmd_data[i] = 16'hA000 + 16'(i);
		cmd(FN_WR_MULTI, 16'h0001, 16'h0008, station);
		chk("multi func", {8'h00, FN_WR_MULTI}, {8'h00, rsp_fn});
		chk("multi strobe", 16'h0002, 16'(strobes - s0));
		for (int i = 0; i < 8; i++)
			chk("multi reg", 16'hA000 + 16'(i), hold_regs[i]);
	endtask
	task automatic t_reads();
		cmd(FN_RD_HOLD, 16'h0001, 16'h0008, station);
		for (int i = 0; i < 8; i++)
			chk("hold word", 16'hA000 + 16'(i), rsp_data[i]);
		cmd(FN_RD_INPUT, 16'h0009, 16'h0008, station);
		for (int i = 0; i < 8; i++)
			chk("input word", 16'h5A08 + 16'(i), rsp_data[i]);
	endtask
	task automatic t_exceptions();
		logic [7:0] fn [5] = '{8'h07, FN_RD_HOLD, FN_RD_INPUT, FN_WR_SINGLE, FN_RD_HOLD};
		logic [15:0] ad [5] = '{16'h0001, 16'h0010, 16'h0001, 16'h0011, 16'h0001};
		logic [15:0] ct [5] = '{16'h0001, 16'h0002, 16'h0000, 16'h0001, 16'h0001};
		logic [7:0] ex [5] = '{EXC_FUNC, EXC_ADDR, EXC_VALUE, EXC_ADDR, EXC_BUSY};
		int s0;
		s0 = strobes;
		for (int i = 0; i < 5; i++)
		begin
			busy = (i == 4);
			cmd(fn[i], ad[i], ct[i], station);
			chk("exc func", {8'h00, fn[i] | EXC_FLAG}, {8'h00, rsp_fn});
			chk("exc code", {8'h00, ex[i]}, {8'h00, rsp_exc});
		end
		busy = 1'b0;
		// Refused requests must leave the registers alone
		chk("exc strobe", 16'h0000, 16'(strobes - s0));
	endtask
	task automatic t_station();
		cmd(FN_RD_HOLD, 16'h0001, 16'h0001, station ^ 8'h01);
		chk("foreign silent", 16'h0001, {15'h0000, rsp_to});
		station = 8'h2C;
		cmd(FN_RD_HOLD, 16'h0001, 16'h0001, 8'h2C);
		chk("new station", 16'h0000, {15'h0000, rsp_to});
	endtask
	// Raw frames on the second link: broken check, good, then two queued back to back
	task automatic t_bad_check();
		logic [7:0] fr [8];
		logic [15:0] c;
		int seen;
		fr = '{station, FN_RD_HOLD, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		c = 16'hFFFF;
		for (int i = 0; i < 6; i++)
			c = tb_crc(c, fr[i]);
		fr[6] = c[7:0];
		fr[7] = c[15:8];
		for (int k = 0; k < 3; k++)
		begin
			for (int i = 0; i < ((k == 2) ? 16 : 8); i++)
			begin
				link_b.m2s_valid = 1'b1;
				link_b.m2s_data = (i == 7 && k == 0) ? ~fr[i % 8] : fr[i % 8];
				link_b.m2s_last = (i % 8 == 7);
				while (link_b.m2s_ready !== 1'b1)
					@(posedge clk) #1;
				@(posedge clk) #1;
			end
			link_b.m2s_valid = 1'b0;
			link_b.m2s_last = 1'b0;
			link_b.m2s_data = ~link_b.m2s_data;
			// The queued second frame fills the FIFO while the first is answered
			chk("fifo ready", {15'h0000, k != 2}, {15'h0000, link_b.m2s_ready});
			seen = 0;
			repeat (60) @(posedge clk) #1 seen += (link_b.s2m_valid === 1'b1 && link_b.s2m_last === 1'b1);
			chk("replies seen", 16'(k), 16'(seen));
		end
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		for (int i = 0; i < 16; i++)
			in_regs[i] = 16'h5A00 + 16'(i);
		link_b.m2s_valid = 1'b0;
		link_b.m2s_data = 8'h00;
		link_b.m2s_last = 1'b0;
		link_b.s2m_ready = 1'b1;
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		t_writes();
		t_reads();
		t_exceptions();
		t_station();
		t_bad_check();
		conclude();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("Error watchdog expected done seen hang");
		conclude();
	end
endmodule
